/* core/ifr_map.vh */
/*
 * Constants for the two-wire memory read sequencer: target address
 * fields, memory geometry and bit counts.
 * Assumes inclusion by core/ifr_read_seq.v only.
 */
`ifndef IFR_MAP_VH
`define IFR_MAP_VH
`define IFR_ADDR_W      11
`define IFR_WORD_W      8
`define IFR_BLK_W       3
`define IFR_BLK_HI      3
`define IFR_BLK_LO      1
`define IFR_DIR_BIT     0
`define IFR_TYPE_HI     7
`define IFR_TYPE_LO     4
`define IFR_TYPE_CODE   4'h5
`define IFR_ADDR_RESET  11'h000
`define IFR_BIT_LAST    4'h7
`define IFR_BIT_ACK     4'h8
`endif

/* core/ifr_read_seq.v */
/*
 * Target-side sequencer of a two-wire serial memory: address byte,
 * word-address load, current-address and sequential reads, write of
 * data bytes into an internal array.
 * Assumes scl and sda arrive from pins, asynchronous to ref_clk, and
 * that ref_clk is many times faster than scl; sda is open drain.
 */
// Summary of operation
// - Current-address read starts at the address latch left by the last access.
// - Read address is three block bits joined with eight latch bits.
// - Data drive starts on the clock right after the acknowledge of the read address byte.
// - Reads run for any length the controller chooses.
// - Address counter advances by one after each data byte read or written; address bytes do not advance it.
// - Controller acknowledge makes the device send the next byte.
// - No-acknowledge then start also ends a read; device releases data.
// - Stop during ninth clock ends the read.
// - Start during ninth clock ends the read, ready for new command.
// - Address wraps from highest location to zero.
// - Write-direction address then word byte loads the address latch.
// - Start after word address abandons write, read proceeds from latch.
// - Bits three to one are block select, bit zero is direction.
// - All bytes shift most significant bit first.
// - Latch increments after each data byte, before the acknowledge.
// - Start anywhere aborts and waits for an address byte.
`timescale 1ns/1ps
`include "ifr_map.vh"

module ifr_read_seq #(
    parameter [3:0] DEV_TYPE = `IFR_TYPE_CODE, // Arbitrary device type code
    parameter       DEPTH    = 2048
) (
    input  wire ref_clk,
    input  wire reset_n,
    input  wire scl_i,
    input  wire sda_i,
    output wire sda_o,
    output wire sda_oe,
    output wire busy,
    output wire [`IFR_ADDR_W-1:0] cur_addr
);

    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_DEVAD = 3'd1;
    localparam [2:0] ST_WORD  = 3'd2;
    localparam [2:0] ST_WDATA = 3'd3;
    localparam [2:0] ST_RDATA = 3'd4;
    localparam [2:0] ST_RACK  = 3'd5;

    reg [`IFR_WORD_W-1:0] mem [0:DEPTH-1];

    reg [1:0] scl_s_q;
    reg [1:0] sda_s_q;
    reg       scl_q;
    reg       sda_q;
    reg [2:0] st_q;
    reg [3:0] bit_q;
    reg [7:0] shr_q;
    reg [`IFR_ADDR_W-1:0] addr_q;
    reg       ack_q;
    reg       drv_q;
    reg       dout_q;
    reg       rd_q;

    wire scl_rise = scl_s_q[1] & ~scl_q;
    wire scl_fall = ~scl_s_q[1] & scl_q;
    wire start_c  = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
    wire stop_c   = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
    wire [7:0] byte_in = {shr_q[6:0], sda_s_q[1]};

    function addr_match;
        input [7:0] b;
        begin
            addr_match = (b[`IFR_TYPE_HI:`IFR_TYPE_LO] == DEV_TYPE);
        end
    endfunction

    function [`IFR_ADDR_W-1:0] next_addr;
        input [`IFR_ADDR_W-1:0] a;
        begin
            next_addr = a + 11'h001; // Natural wrap 7FF to 000
        end
    endfunction

    assign sda_o    = 1'b0;
    assign sda_oe   = (drv_q & ~dout_q) | ack_q;
    assign busy     = (st_q != ST_IDLE);
    assign cur_addr = addr_q;

    // Pin synchronisers
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_s_q <= 2'b11;
            sda_s_q <= 2'b11;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_i};
            sda_s_q <= {sda_s_q[0], sda_i};
            scl_q   <= scl_s_q[1];
            sda_q   <= sda_s_q[1];
        end
    end

    always @(posedge ref_clk) begin
        if (st_q == ST_WDATA && scl_rise && bit_q == `IFR_BIT_LAST) begin
            mem[addr_q] <= byte_in;
        end
    end

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q   <= ST_IDLE;
            bit_q  <= 4'h0;
            shr_q  <= 8'h00;
            addr_q <= `IFR_ADDR_RESET;
            ack_q  <= 1'b0;
            drv_q  <= 1'b0;
            dout_q <= 1'b1;
            rd_q   <= 1'b0;
        end else if (start_c) begin
            // Abort anything, including a write after word address
            st_q  <= ST_DEVAD;
            bit_q <= 4'h0;
            ack_q <= 1'b0;
            drv_q <= 1'b0;
        end else if (stop_c) begin
            st_q  <= ST_IDLE;
            ack_q <= 1'b0;
            drv_q <= 1'b0;
        end else begin
            if (scl_rise) begin
                shr_q <= byte_in; // MSB first
            end
            case (st_q)
            ST_DEVAD, ST_WORD, ST_WDATA: begin
                if (scl_rise && bit_q == `IFR_BIT_LAST) begin
                    bit_q <= `IFR_BIT_ACK;
                    if (st_q == ST_DEVAD) begin
                        if (addr_match(byte_in)) begin
                            // Block select and direction
                            addr_q[`IFR_ADDR_W-1:`IFR_WORD_W] <=
                                byte_in[`IFR_BLK_HI:`IFR_BLK_LO];
                            rd_q <= byte_in[`IFR_DIR_BIT];
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end else if (st_q == ST_WORD) begin
                        addr_q[`IFR_WORD_W-1:0] <= byte_in;
                    end else begin
                        addr_q <= next_addr(addr_q);
                    end
                end else if (scl_rise && bit_q != `IFR_BIT_ACK) begin
                    bit_q <= bit_q + 4'h1;
                end
                if (scl_fall && bit_q == `IFR_BIT_ACK) begin
                    if (!ack_q) begin
                        ack_q <= 1'b1;
                    end else begin
                        ack_q <= 1'b0;
                        bit_q <= 4'h0;
                        if (st_q == ST_DEVAD && rd_q) begin
                            // Drive first bit from latch
                            st_q   <= ST_RDATA;
                            drv_q  <= 1'b1;
                            dout_q <= mem[addr_q][7];
                        end else if (st_q == ST_DEVAD) begin
                            st_q <= ST_WORD;
                        end else begin
                            st_q <= ST_WDATA;
                        end
                    end
                end
            end
            ST_RDATA: begin
                if (scl_fall) begin
                    if (bit_q == `IFR_BIT_LAST) begin
                        // Release for the controller acknowledge
                        drv_q  <= 1'b0;
                        st_q   <= ST_RACK;
                        addr_q <= next_addr(addr_q);
                    end else begin
                        dout_q <= mem[addr_q][3'd6 - bit_q[2:0]];
                        bit_q  <= bit_q + 4'h1;
                    end
                end
            end
            ST_RACK: begin
                if (scl_rise) begin
                    // Acknowledge sampled on ninth clock
                    if (sda_s_q[1]) begin
                        st_q <= ST_IDLE;
                    end else begin
                        bit_q <= 4'h0;
                    end
                end else if (scl_fall) begin
                    st_q   <= ST_RDATA;
                    drv_q  <= 1'b1;
                    dout_q <= mem[addr_q][7];
                end
            end
            default: begin
                bit_q <= 4'h0;
                drv_q <= 1'b0;
                ack_q <= 1'b0;
            end
            endcase
        end
    end

endmodule

/* tb/ifr_read_seq_asserts.sv */
/* Port checker for the read sequencer.
   Assumes the bind below and a pulled-up data wire. */
`timescale 1ns/1ps
module ifr_read_seq_chk (
    input wire        ref_clk,
    input wire        reset_n,
    input wire        scl_i,
    input wire        sda_i,
    input wire        sda_o,
    input wire        sda_oe,
    input wire        busy,
    input wire [10:0] cur_addr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_reset_state: assert property ($rose(reset_n) |->
        !busy && !sda_oe && cur_addr == 11'h000) else $error("reset");
    a_drive_clk_low: assert property ($rose(sda_oe) |-> !scl_i)
        else $error("drive in high");
    a_hold_clk_high: assert property (scl_i |->
        $stable(sda_oe)) else $error("change in high");
    a_start_release: assert property ($fell(sda_i) && scl_i |->
        ##6 !sda_oe [*8]) else $error("drive after start");
    a_stop_idle: assert property ($rose(sda_i) && scl_i |->
        ##6 !busy && !sda_oe) else $error("busy after stop");
    a_wrap_zero: assert property ($past(cur_addr) == 11'h7ff &&
        cur_addr[7:0] == 8'h00 |-> cur_addr == 11'h000) else $error("wrap");
    a_out_low: assert property (sda_oe |-> sda_o == 1'b0)
        else $error("data level");
    a_idle_quiet: assert property (!busy && $past(!busy) |-> !sda_oe)
        else $error("idle drive");
endmodule
bind ifr_read_seq ifr_read_seq_chk ifr_read_seq_chk_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy), .cur_addr(cur_addr));

/* tb/ifr_bus.sv */
/* Bus controller model: clock, data pull-down, conditions.
   Assumes a pull-up on the resolved data wire. */
`timescale 1ns/1ps
module ifr_bus (
    output reg  scl,
    output reg  pull,
    input  wire sda
);
    integer i;
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    task start;
        begin
            #40 pull <= 1'b0;
            #200 scl <= 1'b1;
            #160 pull <= 1'b1;
            #160 scl <= 1'b0;
        end
    endtask
    task stop;
        begin
            #40 pull <= 1'b1;
            #200 scl <= 1'b1;
            #160 pull <= 1'b0;
            #160;
        end
    endtask
    // Bits sent and sampled MSB first
    task bits(input [8:0] tx, input integer n, output reg [8:0] rx);
        begin
            rx = 9'h000;
            for (i = 8; i > 8 - n; i = i - 1) begin
                #40 pull <= !tx[i];
                #200 scl <= 1'b1;
                rx[i] = sda;
                #80 scl <= 1'b0;
            end
        end
    endtask
endmodule

/* tb/ifr_read_seq_tb.sv */
/* Self-checking bench for the read sequencer.
   Assumes the bus model in ifr_bus and the bound checker. */
`timescale 1ns/1ps
module ifr_read_seq_tb;
    localparam [3:0] DEV = 4'h5; // Arbitrary type code
    reg          ref_clk;
    reg          reset_n;
    wire         scl;
    wire         pull;
    wire         sda_oe;
    wire         sda = ~(pull | sda_oe);
    wire  [10:0] cur_addr;
    wire         busy;
    reg   [8:0]  rx;
    integer      errors = 0;
    integer      checks = 0;
    integer      k;
    ifr_read_seq #(.DEV_TYPE(DEV)) ifr_read_seq_inst (.ref_clk(ref_clk),
        .reset_n(reset_n), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe(sda_oe), .busy(busy), .cur_addr(cur_addr));
    ifr_bus ifr_bus_inst (.scl(scl), .pull(pull), .sda(sda));
    task check(input [10:0] seen, input [10:0] want);
        begin
            checks = checks + 1;
            if (seen !== want) begin
                errors = errors + 1;
                $display("unexpected at %0t: %h not %h", $time, seen, want);
            end
        end
    endtask
    task wr(input [8:0] b);
        begin
            ifr_bus_inst.bits(b, 9, rx);
            check({10'h000, rx[0]}, 11'h000);
        end
    endtask
    task rd(input integer n, input nack, input [7:0] want);
        begin
            ifr_bus_inst.bits({8'hff, nack}, n, rx);
            check({3'h0, rx[8:1]}, {3'h0, want});
        end
    endtask
    task t_fill; // Five bytes from 7fe
        begin
            ifr_bus_inst.start;
            wr({DEV, 3'h7, 1'b0, 1'b1});
            wr(9'h1fd);
            for (k = 0; k < 5; k = k + 1)
                wr({8'ha0 + k[7:0], 1'b1});
            ifr_bus_inst.stop;
            check(cur_addr, 11'h003);
            check({10'h000, busy}, 11'h000);
            $display("fill done");
        end
    endtask
    task t_rand; // Selective read over the top
        begin
            ifr_bus_inst.start;
            wr({DEV, 3'h7, 1'b0, 1'b1});
            wr(9'h1fd);
            ifr_bus_inst.start;
            wr({DEV, 3'h7, 1'b1, 1'b1});
            for (k = 0; k < 3; k = k + 1)
                rd(9, k == 2, 8'ha0 + k[7:0]);
            ifr_bus_inst.stop;
            check(cur_addr, 11'h001);
            $display("random done");
        end
    endtask
    task t_cur; // Current read, start endings
        begin
            ifr_bus_inst.start;
            wr({DEV, 3'h0, 1'b1, 1'b1});
            rd(8, 1'b1, 8'ha3);
            ifr_bus_inst.start;
            wr({DEV, 3'h0, 1'b1, 1'b1});
            rd(9, 1'b1, 8'ha4);
            ifr_bus_inst.start;
            ifr_bus_inst.stop;
            check(cur_addr, 11'h003);
            $display("current done");
        end
    endtask
    task t_stop9; // Stop in ninth clock, release
        begin
            ifr_bus_inst.start;
            wr({DEV, 3'h7, 1'b0, 1'b1});
            wr(9'h1ff);
            ifr_bus_inst.start;
            wr({DEV, 3'h7, 1'b1, 1'b1});
            rd(8, 1'b1, 8'ha1);
            ifr_bus_inst.stop;
            check(cur_addr, 11'h000);
            ifr_bus_inst.start;
            wr({DEV, 3'h0, 1'b1, 1'b1});
            rd(9, 1'b1, 8'ha2);
            ifr_bus_inst.bits(9'h1ff, 9, rx);
            check({2'h0, rx}, 11'h1ff);
            check({10'h000, busy}, 11'h000);
            ifr_bus_inst.stop;
            $display("stop9 done");
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d errors %0d", checks, errors);
            if (errors == 0 && checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        errors = errors + 1;
        complete_run;
    end
    initial begin
        reset_n = 1'b0;
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_fill;
        t_rand;
        t_cur;
        t_stop9;
        complete_run;
    end
endmodule
